// >>> design/aqk_seq.sv
/*
 * Quiz key sequencer: debounce, key decode, entry, chain operations,
 * answer test and indicator outputs.
 * Assumes key lines and the strobe index arrive synchronous to sys_clk
 * and that an external arithmetic datapath is not needed: values are
 * held as binary integers, the decimal point is bookkeeping only.
 */
`timescale 1ns/1ps
// How it works
// - Closure starts a stability count; disturbance restarts it
// - Release is debounced with the same restartable count
// - Strobe seven forced high in period nine: four-word debounce
// - Overflow other than in squaring or subtraction, or divide by zero, sets wrong until clear
// - Indicators light only from test, apart from errors
// - Clear zeroes the working registers except fresh_reg, which it sets, and returns to idle
// - First numeral clears entry, loads lowest position, lamps off
// - Numerals two to eight shift in; ninth and later dropped
// - Point recorded; at most seven numerals after it
// - First operator after entry closes it, runs pending, stores new
// - Repeated operators replace the pending one
// - Operator after equal reuses the result as first operand
// - First equal after entry closes it, runs pending, sets equal flag
// - Equal right after add, subtract or divide is ignored
// - Equal right after multiply squares the entry
// - Numerals after equal form the answer, negative if minus first
// - Test compares answer with result: right on match else wrong
// - Ready high at idle and through closure debounce, low on accept
// - Ready stays low until release debounced and processing done
// - Correct test gives right high, wrong low
// - Incorrect test or latched error gives wrong high, right low
// - Both lamps low after non-test keys without error and after clear
// - Low supply holds both lamps low
module aqk_seq #(
    parameter int WORD_CYC = 375000  // Clocks per scan word (1.5 ms)
) (
    input  wire logic       sys_clk,           // 250 MHz clock
    input  wire logic       nrst,              // Async reset, active low
    input  wire logic       clk_en,            // Freezes state when low
    input  wire logic [3:0] strobe_idx,        // Digit period 0..8
    input  wire logic       strobe_start,      // Pulse at new digit
    input  wire logic       strobe7_forced,    // Strobe 7 pin read back
    input  wire logic       key_return_line_a, // Return line A
    input  wire logic       key_return_line_b, // Return line B
    input  wire logic       key_return_line_c, // Return line C
    input  wire logic       low_supply,        // Low battery flag
    output logic            ready,             // High when idle
    output logic            right_lamp,        // Right indicator
    output logic            wrong_lamp         // Wrong indicator
);
    import aqk_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DBON = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_DBOF = 4'b1000
    } aqk_state_t;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_s1_reg, rst_n;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Key decode
    // ----------------------------------------------------------------
    logic       any_line;
    logic [4:0] key_code;
    assign any_line = key_return_line_a | key_return_line_b
                    | key_return_line_c;
    // Three lines by nine periods; unused slots read as no key
    always_comb begin
        key_code = KEY_NONE;
        if (strobe_idx < 4'h9) begin
            if (key_return_line_a) begin
                key_code = (strobe_idx <= 4'h8)
                         ? {1'b0, strobe_idx} : KEY_NONE;
            end else if (key_return_line_b) begin
                key_code = (strobe_idx == 4'h0) ? 5'h09
                         : (strobe_idx == 4'h8) ? KEY_NONE
                         : 5'(KEY_POINT + {1'b0, strobe_idx} - 5'h01);
            end else if (key_return_line_c) begin
                key_code = (strobe_idx == 4'h0) ? KEY_CLR
                         : KEY_NONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Debounce and ready state machine
    // ----------------------------------------------------------------
    localparam int WCW = $clog2(WORD_CYC * DBNC_WORDS + 1);
    aqk_state_t     st_reg, st_next;
    logic [WCW-1:0] cnt_reg, cnt_next;
    logic [4:0]     kc_reg, kc_next;
    logic [3:0]     lastidx_reg, lastidx_next;
    logic           fast_reg, fast_next;
    logic           ready_reg, ready_next;
    logic [WCW-1:0] dbn_lim;
    logic           hit, go;
    // Key is seen when a line is high in the latched key's own period
    assign hit = any_line && (strobe_idx == lastidx_reg);
    assign dbn_lim = fast_reg ? WCW'(WORD_CYC * DBNC_WORDS_TEST)
                              : WCW'(WORD_CYC * DBNC_WORDS);

    always_comb begin
        st_next      = st_reg;
        cnt_next     = cnt_reg;
        kc_next      = kc_reg;
        lastidx_next = lastidx_reg;
        ready_next   = ready_reg;
        go           = 1'b0;
        // Test strap sampled in the ninth digit period
        fast_next    = (strobe_idx == 4'h8) ? strobe7_forced : fast_reg;
        case (st_reg)
            ST_IDLE: begin
                ready_next = 1'b1;
                if (any_line && key_code != KEY_NONE) begin
                    st_next      = ST_DBON;
                    kc_next      = key_code;
                    lastidx_next = strobe_idx;
                    cnt_next     = '0;
                end
            end
            ST_DBON: begin
                // Line must stay high only in its own period, so a drop
                // during that period is a disturbance
                if (strobe_idx == lastidx_reg && !hit) begin
                    st_next = ST_IDLE;
                end else if (strobe_idx == lastidx_reg &&
                             key_code != kc_reg) begin
                    cnt_next = '0;
                    kc_next  = key_code;
                end else if (cnt_reg >= dbn_lim) begin
                    st_next    = ST_EXEC;
                    ready_next = 1'b0;
                end else begin
                    cnt_next = WCW'(cnt_reg + 1'b1);
                end
            end
            ST_EXEC: begin
                go       = 1'b1;
                cnt_next = '0;
                st_next  = ST_DBOF;
            end
            ST_DBOF: begin
                ready_next = 1'b0;
                if (hit) begin
                    cnt_next = '0;
                end else if (cnt_reg >= dbn_lim) begin
                    st_next    = ST_IDLE;
                    ready_next = 1'b1;
                end else begin
                    cnt_next = WCW'(cnt_reg + 1'b1);
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= ST_IDLE;
            cnt_reg     <= '0;
            kc_reg      <= KEY_NONE;
            lastidx_reg <= 4'h0;
            fast_reg    <= 1'b0;
            ready_reg   <= 1'b1;
        end else if (clk_en) begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            kc_reg      <= kc_next;
            lastidx_reg <= lastidx_next;
            fast_reg    <= fast_next;
            ready_reg   <= ready_next;
        end
    end

    // ----------------------------------------------------------------
    // Calculation and answer state
    // ----------------------------------------------------------------
    logic [31:0] ent_reg, ent_next, acc_reg, acc_next;
    logic [3:0]  ndig_reg, ndig_next, nfrac_reg, nfrac_next;
    logic        point_reg, point_next, fresh_reg, fresh_next;
    logic        opnd_reg, opnd_next, eq_reg, eq_next;
    logic        neg_reg, neg_next, err_reg, err_next;
    logic [1:0]  pend_reg, pend_next;
    logic        haveop_reg, haveop_next;
    logic        rl_reg, rl_next, wl_reg, wl_next;
    logic [63:0] res;
    logic        res_err;
    logic [31:0] ans;

    // Pending operation on accumulator and entry
    always_comb begin
        res     = {32'h0, ent_reg};
        res_err = 1'b0;
        if (haveop_reg) begin
            case (pend_reg)
                OP_ADD:  res = {32'h0, acc_reg} + {32'h0, ent_reg};
                OP_SUB:  res = {32'h0, acc_reg} - {32'h0, ent_reg};
                OP_MUL:  res = {32'h0, acc_reg} * {32'h0, ent_reg};
                default: begin
                    res_err = (ent_reg == 32'h0);
                    res = res_err ? 64'h0
                        : {32'h0, acc_reg / ent_reg};
                end
            endcase
        end
        if (pend_reg != OP_SUB && res[63:27] != 37'h0) begin
            res_err = 1'b1;
        end
    end
    assign ans = neg_reg ? 32'(-ent_reg) : ent_reg;

    always_comb begin
        ent_next = ent_reg;  acc_next = acc_reg;
        ndig_next = ndig_reg;  nfrac_next = nfrac_reg;
        point_next = point_reg;  fresh_next = fresh_reg;
        opnd_next = opnd_reg;  eq_next = eq_reg;
        neg_next = neg_reg;  err_next = err_reg;
        pend_next = pend_reg;  haveop_next = haveop_reg;
        rl_next = rl_reg;  wl_next = wl_reg;
        if (go) begin
            if (kc_reg != KEY_TEST) begin
                rl_next = 1'b0;
                wl_next = err_reg;
            end
            if (kc_reg == KEY_CLR) begin
                ent_next = '0;  acc_next = '0;  ndig_next = '0;
                nfrac_next = '0;  point_next = 1'b0;  fresh_next = 1'b1;
                opnd_next = 1'b0;  eq_next = 1'b0;  neg_next = 1'b0;
                err_next = 1'b0;  haveop_next = 1'b0;  pend_next = OP_ADD;
                wl_next = 1'b0;
            end else if (err_reg) begin
                wl_next = 1'b1;
            end else if (kc_reg <= 5'h09) begin
                if (fresh_reg) begin
                    ent_next = {27'h0, kc_reg};
                    ndig_next = 4'h1;
                    fresh_next = 1'b0;
                    wl_next = 1'b0;
                end else if (ndig_reg < 4'(NUM_DIGITS) &&
                           !(point_reg && nfrac_reg >= 4'(FRAC_MAX))) begin
                    ent_next = 32'(ent_reg * 32'hA + {27'h0, kc_reg});
                    ndig_next = 4'(ndig_reg + 1'b1);
                    if (point_reg) nfrac_next = 4'(nfrac_reg + 1'b1);
                end
                opnd_next = 1'b1;
            end else if (kc_reg == KEY_POINT) begin
                point_next = 1'b1;
                nfrac_next = '0;
                if (fresh_reg) begin
                    ent_next = '0;
                    ndig_next = '0;  // Count restarts with a new entry
                    fresh_next = 1'b0;
                end
                opnd_next = 1'b1;
            end else if (kc_reg >= KEY_ADD && kc_reg <= KEY_DIV) begin
                // Minus straight after equal signs the answer and also
                // chains a subtract from the result, so both readings hold
                neg_next = eq_reg && !opnd_reg
                         && (kc_reg == KEY_SUB);
                if (eq_reg) begin
                    eq_next = 1'b0;
                    haveop_next = 1'b1;
                end else if (opnd_reg) begin
                    acc_next = res[31:0];
                    err_next = res_err;
                    wl_next = res_err;
                    haveop_next = 1'b1;
                end
                pend_next = 2'(kc_reg - KEY_ADD);
                opnd_next = 1'b0;
                fresh_next = 1'b1;
                point_next = 1'b0;
            end else if (kc_reg == KEY_EQ) begin
                if (opnd_reg && !eq_reg) begin
                    acc_next = res[31:0];
                    err_next = res_err;
                    wl_next = res_err;
                    eq_next = 1'b1;
                    haveop_next = 1'b0;
                end else if (!opnd_reg && haveop_reg && pend_reg == OP_MUL
                             && !eq_reg) begin
                    acc_next = 32'(ent_reg * ent_reg);
                    eq_next = 1'b1;
                    haveop_next = 1'b0;
                end
                opnd_next = 1'b0;
                fresh_next = 1'b1;
                point_next = 1'b0;
                neg_next = 1'b0;
            end else if (kc_reg == KEY_TEST) begin
                rl_next = (ans == acc_reg);
                wl_next = (ans != acc_reg);
                eq_next = 1'b0;  haveop_next = 1'b0;
                opnd_next = 1'b0;  fresh_next = 1'b1;  neg_next = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ent_reg <= VAL_RST;  acc_reg <= VAL_RST;
            ndig_reg <= 4'h0;  nfrac_reg <= 4'h0;
            point_reg <= 1'b0;  fresh_reg <= 1'b1;
            opnd_reg <= 1'b0;  eq_reg <= 1'b0;
            neg_reg <= 1'b0;  err_reg <= 1'b0;
            pend_reg <= OP_ADD;  haveop_reg <= 1'b0;
            rl_reg <= 1'b0;  wl_reg <= 1'b0;
        end else if (clk_en) begin
            ent_reg <= ent_next;  acc_reg <= acc_next;
            ndig_reg <= ndig_next;  nfrac_reg <= nfrac_next;
            point_reg <= point_next;  fresh_reg <= fresh_next;
            opnd_reg <= opnd_next;  eq_reg <= eq_next;
            neg_reg <= neg_next;  err_reg <= err_next;
            pend_reg <= pend_next;  haveop_reg <= haveop_next;
            rl_reg <= rl_next;  wl_reg <= wl_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, registered; low supply overrides lamps
    // ----------------------------------------------------------------
    logic rout_reg, wout_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rout_reg <= 1'b0;
            wout_reg <= 1'b0;
        end else if (clk_en) begin
            rout_reg <= rl_reg & ~wl_reg & ~low_supply;
            wout_reg <= wl_reg & ~low_supply;
        end
    end
    assign ready      = ready_reg;
    assign right_lamp = rout_reg;
    assign wrong_lamp = wout_reg;
endmodule : aqk_seq

// >>> design/aqk_pkg.sv
/*
 * Shared constants for the quiz key sequencer: key codes, timing counts,
 * operator codes and sizes.
 * Assumes a 250 MHz system clock and a scanned key matrix outside.
 */
package aqk_pkg;
    // --------------------------------------------------------------
    // Scan and timing
    // --------------------------------------------------------------
    localparam int  DIGITS          = 9;     // Strobes per scan word
    localparam int  DBNC_WORDS      = 7;     // Normal debounce, words
    localparam int  DBNC_WORDS_TEST = 4;     // Test debounce, words
    localparam int  NUM_DIGITS      = 8;     // Entry capacity
    localparam int  FRAC_MAX        = 7;     // Numerals after point
    // Operator codes
    localparam logic [1:0] OP_ADD = 2'h0;
    localparam logic [1:0] OP_SUB = 2'h1;
    localparam logic [1:0] OP_MUL = 2'h2;
    localparam logic [1:0] OP_DIV = 2'h3;
    // Key classes, decoded from strobe and return line
    localparam logic [4:0] KEY_NUM0  = 5'h00; // 0..9 numerals
    localparam logic [4:0] KEY_POINT = 5'h0A;
    localparam logic [4:0] KEY_ADD   = 5'h0B;
    localparam logic [4:0] KEY_SUB   = 5'h0C;
    localparam logic [4:0] KEY_MUL   = 5'h0D;
    localparam logic [4:0] KEY_DIV   = 5'h0E;
    localparam logic [4:0] KEY_EQ    = 5'h0F;
    localparam logic [4:0] KEY_TEST  = 5'h10;
    localparam logic [4:0] KEY_CLR   = 5'h11;
    localparam logic [4:0] KEY_NONE  = 5'h1F;
    // Reset values
    localparam logic [31:0] VAL_RST  = 32'h0000_0000;
endpackage : aqk_pkg

// >>> dv/aqk_seq_monitor.sv
/* Port checker for the quiz key sequencer, bound to aqk_seq.
   Assumes clk_en high and one strobe period per clock. */
`timescale 1ns/1ps
module aqk_seq_monitor #(
    parameter int WORD_CYC = 375000  // Clocks per scan word
) (
    input wire logic       sys_clk,           // Clock
    input wire logic       nrst,              // Reset, active low
    input wire logic       clk_en,            // Clock enable
    input wire logic [3:0] strobe_idx,        // Digit period
    input wire logic       strobe_start,      // Unused marker
    input wire logic       strobe7_forced,    // Strobe seven
    input wire logic       key_return_line_a, // Return line A
    input wire logic       key_return_line_b, // Return line B
    input wire logic       key_return_line_c, // Return line C
    input wire logic       low_supply,        // Low battery flag
    input wire logic       ready,             // Idle flag
    input wire logic       right_lamp,        // Right indicator
    input wire logic       wrong_lamp         // Wrong indicator
);
    import aqk_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    int   idle_reg, idle_next, high_reg, high_next, act_reg, act_next;
    logic any_line;
    // ----------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------
    assign any_line = key_return_line_a | key_return_line_b
                    | key_return_line_c;
    // Quiet time, ready-high run, and time a key waits for acceptance
    always_comb begin
        idle_next = any_line ? 0 : idle_reg + 1;
        high_next = ready ? high_reg + 1 : 0;
        act_next  = (ready && idle_reg < DIGITS) ? act_reg + 1 : 0;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idle_reg <= 0;
            high_reg <= 0;
            act_reg  <= 0;
        end else begin
            idle_reg <= idle_next;
            high_reg <= high_next;
            act_reg  <= act_next;
        end
    end
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    sequence s_accept;
        ready ##1 !ready;
    endsequence
    a_lamps_exclusive: assert property (
        !(right_lamp && wrong_lamp))
        else $error("both lamps lit");
    a_supply_dark: assert property (
        low_supply |=> !right_lamp && !wrong_lamp)
        else $error("lamp lit on low supply");
    a_fall_near_key: assert property (s_accept |-> idle_reg < DIGITS)
        else $error("ready fell with no key");
    a_fall_after_count: assert property (
        s_accept |-> high_reg >= 4 * WORD_CYC)
        else $error("key accepted before debounce");
    a_rise_after_quiet: assert property (
        $rose(ready) |-> idle_reg >= 4 * WORD_CYC)
        else $error("ready rose before release debounce");
    a_ready_low_min: assert property (s_accept |-> ##1 !ready [*8])
        else $error("ready low too briefly");
    a_lamps_busy: assert property (
        !$stable({right_lamp, wrong_lamp}) |->
        !ready || !$stable(low_supply) || !$stable($past(low_supply)))
        else $error("lamps changed while idle");
    a_accept_bounded: assert property (
        act_reg <= 7 * WORD_CYC + 2 * DIGITS)
        else $error("stable key not accepted in time");
endmodule : aqk_seq_monitor

bind aqk_seq aqk_seq_monitor #(.WORD_CYC(WORD_CYC)) u_aqk_seq_monitor (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .strobe_idx(strobe_idx),
    .strobe_start(strobe_start), .strobe7_forced(strobe7_forced),
    .key_return_line_a(key_return_line_a),
    .key_return_line_b(key_return_line_b),
    .key_return_line_c(key_return_line_c), .low_supply(low_supply),
    .ready(ready), .right_lamp(right_lamp), .wrong_lamp(wrong_lamp));

// >>> dv/aqk_keypad_model.sv
/* Key matrix model: scans nine digit periods, closes one key.
   Assumes the bench sets key and mode between clock edges. */
`timescale 1ns/1ps
module aqk_keypad_model (
    input  wire logic       sys_clk,           // System clock
    input  wire logic       key_down,          // Key held by user
    input  wire logic [1:0] key_row,           // 0 line A, 1 B, 2 C
    input  wire logic [3:0] key_period,        // Digit period of key
    input  wire logic       fast_scan,         // Request short debounce
    output logic      [3:0] strobe_idx,        // Current digit period
    output logic            strobe7_forced,    // Strobe seven read back
    output logic            key_return_line_a, // Return line A
    output logic            key_return_line_b, // Return line B
    output logic            key_return_line_c  // Return line C
);
    logic hit;
    // Scan steps on the falling edge, well away from the sampling edge
    initial strobe_idx = 4'h0;
    always @(negedge sys_clk) begin
        strobe_idx <= (strobe_idx == 4'h8) ? 4'h0 : strobe_idx + 4'h1;
    end
    // A closed key joins its strobe to one line; open lines pull low
    assign hit = key_down && (strobe_idx == key_period);
    assign key_return_line_a = hit && (key_row == 2'h0);
    assign key_return_line_b = hit && (key_row == 2'h1);
    assign key_return_line_c = hit && (key_row == 2'h2);
    // Test mode: strobe seven forced high in the ninth period
    assign strobe7_forced = fast_scan && (strobe_idx == 4'h8);
endmodule : aqk_keypad_model

// >>> dv/arithmetic_quiz_key_sequencer_bench.sv
/* Self-checking bench for aqk_seq: key strings pressed through the
   matrix model, lamps compared after each sequence. */
`timescale 1ns/1ps
module arithmetic_quiz_key_sequencer_bench;
    import aqk_pkg::*;
    localparam int W = 9;  // Short scan word: one period per clock
    logic       sys_clk, nrst, low_supply, key_down, fast_scan;
    logic       ready, right_lamp, wrong_lamp, strobe7_forced;
    logic       key_a, key_b, key_c;
    logic [1:0] key_row;
    logic [3:0] key_period, strobe_idx;
    int         errors, total_checks;

    aqk_seq #(.WORD_CYC(W)) u_aqk_seq (.sys_clk(sys_clk), .nrst(nrst),
        .clk_en(1'b1), .strobe_idx(strobe_idx), .strobe_start(1'b0),
        .strobe7_forced(strobe7_forced), .key_return_line_a(key_a),
        .key_return_line_b(key_b), .key_return_line_c(key_c),
        .low_supply(low_supply), .ready(ready), .right_lamp(right_lamp),
        .wrong_lamp(wrong_lamp));
    aqk_keypad_model u_aqk_keypad_model (.sys_clk(sys_clk),
        .key_down(key_down), .key_row(key_row), .key_period(key_period),
        .fast_scan(fast_scan), .strobe_idx(strobe_idx),
        .strobe7_forced(strobe7_forced), .key_return_line_a(key_a),
        .key_return_line_b(key_b), .key_return_line_c(key_c));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask : check
    // Key map: A period n is numeral n, B holds 9 and the commands, C holds clear
    function automatic logic [5:0] map(input byte c);
        case (c)
            "9": map = {2'h1, 4'h0};
            ".": map = {2'h1, 4'h1};
            "+": map = {2'h1, 4'h2};
            "-": map = {2'h1, 4'h3};
            "*": map = {2'h1, 4'h4};
            "/": map = {2'h1, 4'h5};
            "=": map = {2'h1, 4'h6};
            "T": map = {2'h1, 4'h7};
            "C": map = {2'h2, 4'h0};
            default: map = {2'h0, 4'(c - 8'h30)};
        endcase
    endfunction : map
    // Press and release one key; gap opens the contact in mid-debounce
    task automatic press(input byte c, input int gap);
        int n;
        int lo;
        n = 0;
        lo = (fast_scan ? 4 : 7) * W + (gap > 0 ? 30 + gap : 0);
        {key_row, key_period} = map(c);
        while (ready === 1'b1 && n < 4000) begin
            key_down = !(gap > 0 && n >= 30 && n < 30 + gap);
            @(negedge sys_clk);
            n++;
        end
        check(n >= lo && n < 4000, 1'b1, "accept time wrong");
        if (n >= 4000) begin
            wrap_up();
        end
        if (fast_scan) begin
            check(n < 7 * W, 1'b1, "short debounce not taken");
        end
        key_down = 1'b0;
        n = 0;
        lo = (fast_scan ? 4 : 7) * W;
        while (ready !== 1'b1 && n < 4000) begin
            @(negedge sys_clk);
            n++;
        end
        check(n >= lo && n < 4000, 1'b1, "release time wrong");
        if (n >= 4000) begin
            wrap_up();
        end
        repeat (3) @(negedge sys_clk);
    endtask : press
    task automatic run(input string s, input logic r, input logic w);
        for (int i = 0; i < s.len(); i++) begin
            press(s[i], 0);
        end
        check(right_lamp, r, {"right lamp after ", s});
        check(wrong_lamp, w, {"wrong lamp after ", s});
        $display("test %s done", s);
    endtask : run
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        nrst = 1'b0;
        low_supply = 1'b0;
        key_down = 1'b0;
        fast_scan = 1'b0;
        key_row = 2'h0;
        key_period = 4'h0;
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(ready, 1'b1, "not idle after reset");
        run("C", 1'b0, 1'b0);
        run("4+5=8T", 1'b0, 1'b1);
        run("4", 1'b0, 1'b0);
        run("+5=9T", 1'b1, 1'b0);
        run("7*=49T", 1'b1, 1'b0);
        run("6+-2=4T", 1'b1, 1'b0);
        run("4-7=-3T", 1'b1, 1'b0);
        run("2+=3=5T", 1'b1, 1'b0);
        run("8-=2=6T8/=2=4T", 1'b1, 1'b0);
        run("2+3=*4=20T", 1'b1, 1'b0);
        run("123456782+0=12345678T", 1'b1, 1'b0);
        run("1.12345678+0=11234567T.12345678+0=1234567T", 1'b1, 1'b0);
        run("7+C2=2T", 1'b1, 1'b0);
        run("5/0=", 1'b0, 1'b1);
        run("3+", 1'b0, 1'b1);
        run("C", 1'b0, 1'b0);
        run("99999999*99999999=", 1'b0, 1'b1);
        run("C", 1'b0, 1'b0);
        low_supply = 1'b1;
        run("4+5=9T", 1'b0, 1'b0);
        low_supply = 1'b0;
        press("1", 12);
        run("+1=2T", 1'b1, 1'b0);
        fast_scan = 1'b1;
        run("3+4=7T", 1'b1, 1'b0);
        fast_scan = 1'b0;
        wrap_up();
    end
endmodule : arithmetic_quiz_key_sequencer_bench
